/* File: common/rsa_pkg.sv */
package rsa_pkg;

	// ----------------------------------------------------------------
	// Data memory geometry
	// ----------------------------------------------------------------
	localparam int unsigned RAM_WORDS    = 256;
	localparam int unsigned ADDR_W       = 8;
	localparam int unsigned NIB_W        = 4;
	localparam int unsigned PC_W         = 12;

	// ----------------------------------------------------------------
	// Special addresses
	// ----------------------------------------------------------------
	localparam logic [7:0] STACK_BASE    = 8'hC0;
	localparam logic [7:0] STACK_END     = 8'hFB;
	localparam logic [3:0] STACK_LAST    = 4'hE;
	localparam logic [7:0] CNT1_LOW      = 8'hF4;
	localparam logic [7:0] CNT1_MID      = 8'hF5;
	localparam logic [7:0] CNT1_HIGH     = 8'hF6;
	localparam logic [7:0] CNT2_LOW      = 8'hF8;
	localparam logic [7:0] CNT2_MID      = 8'hF9;
	localparam logic [7:0] CNT2_HIGH     = 8'hFA;
	localparam logic [7:0] TPTR_LOW      = 8'hFC;
	localparam logic [7:0] TPTR_MID      = 8'hFD;
	localparam logic [7:0] TPTR_HIGH     = 8'hFE;
	localparam logic [7:0] SLI_ADDR      = 8'hFF;
	localparam logic [3:0] ZERO_PAGE     = 4'h0;

	// ----------------------------------------------------------------
	// Word order inside one stack location
	// ----------------------------------------------------------------
	localparam logic [1:0] SLOT_PC_LOW   = 2'h0;
	localparam logic [1:0] SLOT_PC_MID   = 2'h1;
	localparam logic [1:0] SLOT_PC_HIGH  = 2'h2;
	localparam logic [1:0] SLOT_FLAGS    = 2'h3;

	// ----------------------------------------------------------------
	// Sequencer commands
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		CMD_NONE,
		CMD_CALL,
		CMD_INT_ACCEPT,
		CMD_SUB_RETURN,
		CMD_INT_RETURN
	} rsa_cmd_t;

	typedef struct packed {
		logic carryFlag;
		logic zeroFlag;
		logic branchConditionFlag;
		logic generalFlag;
	} rsa_flags_t;

	typedef struct packed {
		logic       rd;
		logic       wr;
		logic       zeroPage;
		logic [7:0] addr;
		logic [3:0] wdata;
	} rsa_ram_req_t;

endpackage

/* File: hw/rsa_ram_stack.sv */
// Functional notes
// - Call saves return PC into the location named by the stack index word.
// - Interrupt acceptance saves PC and flags into the current location.
// - Subroutine return reloads PC only; interrupt return reloads PC and flags.
// - Fifteen locations 0..14, four nibbles each, ending at FB.
// - Location n starts at C0 plus four times n; location 3 is CC..CF.
// - Index decrements after save and increments before restore.
// - Stack index word is RAM nibble FF, software and hardware writable.
// - No overflow check; saves overwrite whatever RAM lies there.
// - Two 12-bit counts in nibbles F4..F6 and F8..FA.
// - Count nibbles are plain RAM-readable and RAM-writable words.
// - Nibbles F7 and FB stay ordinary RAM.
// - Zero-page addressing reaches words 00..0F directly.
// - Table pointer is 12 bits; a tableAdvance pulse in idle, with no RAM write, post-increments it.
// - Saved flags are carry, zero, branch condition and general flag.
module rsa_ram_stack (
	input  wire logic                  clk_sys,
	input  wire logic                  reset_n,
	input  wire rsa_pkg::rsa_ram_req_t ramReq,
	output logic [3:0]                 ramRdata,
	input  wire rsa_pkg::rsa_cmd_t     stackCmd,
	input  wire logic [11:0]           pcIn,
	input  wire rsa_pkg::rsa_flags_t   flagsIn,
	output logic                       stackBusy,
	output logic                       restoreValid,
	output logic                       restoreFlagsValid,
	output logic [11:0]                pcOut,
	output rsa_pkg::rsa_flags_t        flagsOut,
	input  wire logic                  tableAdvance,
	output logic [11:0]                tablePointer,
	output logic [11:0]                firstCountRegister,
	output logic [11:0]                secondCountRegister,
	output logic [3:0]                 stackLocationIndex
);
	import rsa_pkg::*;

	// ----------------------------------------------------------------
	// Storage
	// ----------------------------------------------------------------
	// Left unreset on purpose: RAM and the index word power up unknown
	logic [3:0] ramMem [RAM_WORDS];

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_SAVE,
		ST_PRE_INC,
		ST_LOAD,
		ST_DONE
	} rsa_state_t;

	rsa_state_t  state_q, state_d;
	logic [1:0]  slot_q, slot_d;
	logic        withFlags_q, withFlags_d;
	logic [11:0] pc_q;
	rsa_flags_t  flags_q;
	logic [11:0] pcLoad_q;
	logic [3:0]  rdata_q;
	logic [11:0] tpNext;

	// Word address of one nibble in a stack location
	function automatic logic [7:0] slotAddr(input logic [3:0] loc, input logic [1:0] slot);
		slotAddr = STACK_BASE + {2'h0, loc, 2'h0} + {6'h00, slot};
	endfunction

	// Word address of a software access; zero page ignores the page bits
	function automatic logic [7:0] ramAddr(input rsa_ram_req_t req);
		ramAddr = req.zeroPage ? {ZERO_PAGE, req.addr[3:0]} : req.addr;
	endfunction

	// Nibble of the captured PC or flags for a given slot
	function automatic logic [3:0] slotData(input logic [11:0] pc, input rsa_flags_t fl,
			input logic [1:0] slot);
		case (slot)
			SLOT_PC_LOW:  slotData = pc[3:0];
			SLOT_PC_MID:  slotData = pc[7:4];
			SLOT_PC_HIGH: slotData = pc[11:8];
			default:      slotData = fl;
		endcase
	endfunction

	assign stackLocationIndex = ramMem[SLI_ADDR];
	assign tablePointer       = {ramMem[TPTR_HIGH], ramMem[TPTR_MID], ramMem[TPTR_LOW]};
	assign firstCountRegister = {ramMem[CNT1_HIGH], ramMem[CNT1_MID], ramMem[CNT1_LOW]};
	assign secondCountRegister = {ramMem[CNT2_HIGH], ramMem[CNT2_MID], ramMem[CNT2_LOW]};
	assign tpNext             = tablePointer + 12'h001;
	assign stackBusy          = (state_q != ST_IDLE);

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	// Next state: saves stream four nibbles, restores bump the index first
	always_comb begin
		state_d     = state_q;
		slot_d      = slot_q;
		withFlags_d = withFlags_q;
		case (state_q)
			ST_IDLE: begin
				slot_d = SLOT_PC_LOW;
				case (stackCmd)
					CMD_CALL: begin
						state_d     = ST_SAVE;
						withFlags_d = 1'b0;
					end
					CMD_INT_ACCEPT: begin
						state_d     = ST_SAVE;
						withFlags_d = 1'b1;
					end
					CMD_SUB_RETURN: begin
						state_d     = ST_PRE_INC;
						withFlags_d = 1'b0;
					end
					CMD_INT_RETURN: begin
						state_d     = ST_PRE_INC;
						withFlags_d = 1'b1;
					end
					default: state_d = ST_IDLE;
				endcase
			end
			ST_SAVE: begin
				slot_d = slot_q + 2'h1;
				if (slot_q == SLOT_FLAGS) begin
					state_d = ST_DONE;
				end
			end
			ST_PRE_INC: state_d = ST_LOAD;
			ST_LOAD: begin
				slot_d = slot_q + 2'h1;
				if (slot_q == SLOT_FLAGS) begin
					state_d = ST_DONE;
				end
			end
			ST_DONE: state_d = ST_IDLE;
			default: state_d = ST_IDLE;
		endcase
	end

	// Control state registers
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			state_q     <= ST_IDLE;
			slot_q      <= 2'h0;
			withFlags_q <= 1'b0;
		end else begin
			state_q     <= state_d;
			slot_q      <= slot_d;
			withFlags_q <= withFlags_d;
		end
	end

	// Capture PC and flags at the command so the sequencer may move on
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			pc_q    <= 12'h000;
			flags_q <= 4'h0;
		end else if (state_q == ST_IDLE && stackCmd != CMD_NONE) begin
			pc_q    <= pcIn;
			flags_q <= flagsIn;
		end
	end

	// ----------------------------------------------------------------
	// RAM write port
	// ----------------------------------------------------------------
	// Stack traffic owns the array while busy; software writes are
	// ignored then, so the sequencer must not issue RAM ops meanwhile
	always_ff @(posedge clk_sys) begin
		if (state_q == ST_SAVE) begin
			// No bound check: a runaway stack overwrites user data
			ramMem[slotAddr(stackLocationIndex, slot_q)] <=
				slotData(pc_q, flags_q, slot_q);
			if (slot_q == SLOT_FLAGS) begin
				ramMem[SLI_ADDR] <= stackLocationIndex - 4'h1;
			end
		end else if (state_q == ST_PRE_INC) begin
			ramMem[SLI_ADDR] <= stackLocationIndex + 4'h1;
		end else if (state_q == ST_IDLE) begin
			if (ramReq.wr) begin
				// F7, FB and counter nibbles are plain words here
				ramMem[ramAddr(ramReq)] <= ramReq.wdata;
			end else if (tableAdvance) begin
				ramMem[TPTR_LOW]  <= tpNext[3:0];
				ramMem[TPTR_MID]  <= tpNext[7:4];
				ramMem[TPTR_HIGH] <= tpNext[11:8];
			end
		end
	end

	// ----------------------------------------------------------------
	// Read data and restore results
	// ----------------------------------------------------------------
	// Registered read, one cycle after the request
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			rdata_q <= 4'h0;
		end else if (ramReq.rd && state_q == ST_IDLE) begin
			rdata_q <= ramMem[ramAddr(ramReq)];
		end
	end
	assign ramRdata = rdata_q;

	// Gather restored PC nibbles; on interrupt return the flags nibble goes straight to flagsOut
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			pcLoad_q <= 12'h000;
		end else if (state_q == ST_LOAD) begin
			case (slot_q)
				SLOT_PC_LOW:  pcLoad_q[3:0]  <= ramMem[slotAddr(stackLocationIndex, slot_q)];
				SLOT_PC_MID:  pcLoad_q[7:4]  <= ramMem[slotAddr(stackLocationIndex, slot_q)];
				SLOT_PC_HIGH: pcLoad_q[11:8] <= ramMem[slotAddr(stackLocationIndex, slot_q)];
				default:      pcLoad_q       <= pcLoad_q;
			endcase
		end
	end

	// Present restored values at the end of a restore; the valid strobes last one cycle, pcOut and flagsOut hold
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			restoreValid      <= 1'b0;
			restoreFlagsValid <= 1'b0;
			pcOut             <= 12'h000;
			flagsOut          <= 4'h0;
		end else begin
			restoreValid      <= 1'b0;
			restoreFlagsValid <= 1'b0;
			if (state_q == ST_LOAD && slot_q == SLOT_FLAGS) begin
				restoreValid      <= 1'b1;
				restoreFlagsValid <= withFlags_q;
				pcOut             <= pcLoad_q;
				if (withFlags_q) begin
					flagsOut <= ramMem[slotAddr(stackLocationIndex, slot_q)];
				end
			end
		end
	end

endmodule

/* File: verification/rsa_ram_stack_checker.sv */
module rsa_ram_stack_checker (
	input wire logic                  clk_sys,
	input wire logic                  reset_n,
	input wire rsa_pkg::rsa_ram_req_t ramReq,
	input wire logic [3:0]            ramRdata,
	input wire rsa_pkg::rsa_cmd_t     stackCmd,
	input wire logic                  stackBusy,
	input wire logic                  restoreValid,
	input wire logic                  restoreFlagsValid,
	input wire logic                  tableAdvance,
	input wire logic [11:0]           tablePointer,
	input wire logic [11:0]           firstCountRegister,
	input wire logic [3:0]            stackLocationIndex
);
	timeunit 1ns;
	timeprecision 1ns;
	import rsa_pkg::*;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	// ---------------------------------------------
	// Command decode: only idle edges take a command
	// ---------------------------------------------
	wire logic isSave = !stackBusy && stackCmd inside {CMD_CALL, CMD_INT_ACCEPT};
	wire logic isRet  = !stackBusy && stackCmd inside {CMD_SUB_RETURN, CMD_INT_RETURN};
	busy_hold_a: assert property ((isSave || isRet) |=> stackBusy[*5])
		else $error("busy dropped early");
	save_dec_a: assert property (isSave |-> ##6 stackLocationIndex == $past(stackLocationIndex, 6) - 4'h1)
		else $error("index not decremented");
	ret_inc_a: assert property (isRet |-> ##4 stackLocationIndex == $past(stackLocationIndex, 4) + 4'h1)
		else $error("index not incremented");
	ret_pulse_a: assert property (isRet |-> ##6 restoreValid && restoreFlagsValid == ($past(stackCmd, 6) == CMD_INT_RETURN))
		else $error("restore pulse wrong");
	pulse_once_a: assert property (restoreValid |=> !restoreValid)
		else $error("restore pulse too long");
	flag_pair_a: assert property (restoreFlagsValid |-> restoreValid)
		else $error("flags restored alone");
	rdata_hold_a: assert property (!ramReq.rd |=> $stable(ramRdata))
		else $error("read data moved");
	tptr_inc_a: assert property (tableAdvance && !ramReq.wr && !stackBusy |=> tablePointer == $past(tablePointer) + 12'h001)
		else $error("table pointer not advanced");
	cnt_view_a: assert property (ramReq.wr && !ramReq.zeroPage && ramReq.addr == CNT1_HIGH && !stackBusy |=> firstCountRegister[11:8] == $past(ramReq.wdata))
		else $error("count view stale");
endmodule
bind rsa_ram_stack rsa_ram_stack_checker rsa_ram_stack_checker_i (.clk_sys, .reset_n, .ramReq, .ramRdata, .stackCmd, .stackBusy, .restoreValid, .restoreFlagsValid, .tableAdvance, .tablePointer, .firstCountRegister, .stackLocationIndex);

/* File: verification/rsa_seq_model.sv */
module rsa_seq_model (
	input  wire logic          clk_sys,
	input  wire logic          stackBusy,
	output rsa_pkg::rsa_cmd_t   stackCmd,
	output logic [11:0]        pcIn,
	output rsa_pkg::rsa_flags_t flagsIn
);
	timeunit 1ns;
	timeprecision 1ns;
	import rsa_pkg::*;
	initial begin
		stackCmd = CMD_NONE;
		pcIn = '0;
		flagsIn = '0;
	end
	// ---------------------------------------------
	// Sequencer: one command per idle slot, then wait
	// ---------------------------------------------
	task automatic issue(input rsa_cmd_t c, input logic [11:0] p, input rsa_flags_t f);
		int n;
		n = 0;
		while (stackBusy && n < 20) begin // Busy edges drop commands
			@(posedge clk_sys);
			#1 n++;
		end
		stackCmd = c;
		pcIn = p;
		flagsIn = f;
		@(posedge clk_sys);
		#1 stackCmd = CMD_NONE;
		pcIn = ~p; // Released: no stale value
		flagsIn = ~f;
		n = 0;
		while (stackBusy && n < 20) begin
			@(posedge clk_sys);
			#1 n++;
		end
	endtask
endmodule

/* File: verification/rsa_ram_stack_tb_top.sv */
`define CHK(n, e, a) begin comparisons++; if ((a) !== (e)) begin fails++; $display("BAD %s exp %h got %h", n, e, a); end end
module rsa_ram_stack_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import rsa_pkg::*;
	logic clk_sys, reset_n, stackBusy, restoreValid, restoreFlagsValid, tableAdvance;
	rsa_ram_req_t ramReq;
	logic [3:0] ramRdata, stackLocationIndex, d;
	rsa_cmd_t stackCmd;
	logic [11:0] pcIn, pcOut, tablePointer, firstCountRegister, secondCountRegister, t;
	rsa_flags_t flagsIn, flagsOut;
	logic [11:0] pc [3];
	rsa_flags_t fl [3];
	int fails = 0, comparisons = 0, seed = 93, k, j;
	rsa_ram_stack rsa_ram_stack_i (.clk_sys, .reset_n, .ramReq, .ramRdata, .stackCmd, .pcIn,
		.flagsIn, .stackBusy, .restoreValid, .restoreFlagsValid, .pcOut, .flagsOut,
		.tableAdvance, .tablePointer, .firstCountRegister, .secondCountRegister,
		.stackLocationIndex);
	rsa_seq_model rsa_seq_model_i (.clk_sys, .stackBusy, .stackCmd, .pcIn, .flagsIn);
	always #5 clk_sys = ~clk_sys;
	// ---------------------------------------------
	// Access helpers; one idle cycle between requests
	// ---------------------------------------------
	task automatic acc(input logic r, input logic [7:0] a, input logic [3:0] v, input logic z);
		ramReq = '{r, !r, z, a, v};
		@(posedge clk_sys);
		#1 ramReq = '0;
		@(posedge clk_sys);
		#1;
	endtask
	task automatic rd(input logic [7:0] a, input logic [3:0] e);
		acc(1'b1, a, 4'h0, 1'b0);
		`CHK("ram", e, ramRdata)
	endtask
	function automatic logic [3:0] slot(input logic [11:0] p, input rsa_flags_t f, input int s);
		return s == 3 ? f : p[4*s+:4]; // Low, mid, high, flags
	endfunction
	task automatic results;
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		#100000 fails++;
		results;
	end
	initial begin
		clk_sys = 0;
		reset_n = 0;
		ramReq = '0;
		tableAdvance = 0;
		repeat (6) @(posedge clk_sys);
		#1 reset_n = 1;
		acc(1'b0, SLI_ADDR, 4'hC, 1'b0);
		rd(SLI_ADDR, 4'hC);
		for (k = 0; k < 3; k++) begin
			pc[k] = 12'($random(seed));
			fl[k] = 4'($random(seed));
			rsa_seq_model_i.issue(k == 1 ? CMD_INT_ACCEPT : CMD_CALL, pc[k], fl[k]);
			`CHK("index", 4'hB - 4'(k), stackLocationIndex)
			for (j = 0; j < 3 + (k == 1); j++)
				rd(STACK_BASE + 8'(4 * (12 - k) + j), slot(pc[k], fl[k], j));
		end
		for (k = 2; k >= 0; k--) begin
			rsa_seq_model_i.issue(k == 1 ? CMD_INT_RETURN : CMD_SUB_RETURN, 12'h000, 4'h0);
			`CHK("pc", pc[k], pcOut)
			`CHK("flags", k == 2 ? 4'h0 : fl[1], flagsOut)
			`CHK("index", 4'hC - 4'(k), stackLocationIndex)
		end
		$display("stack nesting done");
		acc(1'b0, 8'hCC, 4'h5, 1'b0);
		acc(1'b0, SLI_ADDR, 4'h3, 1'b0);
		rsa_seq_model_i.issue(CMD_CALL, 12'hABC, 4'h0);
		for (j = 0; j < 3; j++)
			rd(8'hCC + 8'(j), slot(12'hABC, 4'h0, j));
		$display("location three done");
		t = 12'($random(seed));
		for (j = 0; j < 3; j++) begin
			acc(1'b0, CNT1_LOW + 8'(j), t[4*j+:4], 1'b0);
			acc(1'b0, CNT2_LOW + 8'(j), ~t[4*j+:4], 1'b0);
		end
		`CHK("cnt1", t, firstCountRegister)
		`CHK("cnt2", ~t, secondCountRegister)
		rd(CNT2_MID, ~t[7:4]);
		acc(1'b0, 8'hF7, t[3:0], 1'b0);
		acc(1'b0, STACK_END, t[7:4], 1'b0);
		rd(8'hF7, t[3:0]);
		rd(STACK_END, t[7:4]);
		$display("count words done");
		for (k = 0; k < 2; k++) begin
			t = k ? 12'hFFF : 12'($random(seed));
			for (j = 0; j < 3; j++)
				acc(1'b0, TPTR_LOW + 8'(j), t[4*j+:4], 1'b0);
			`CHK("tptr", t, tablePointer)
			tableAdvance = 1;
			@(posedge clk_sys);
			#1 tableAdvance = 0;
			`CHK("tptr", t + 12'h001, tablePointer)
		end
		$display("table pointer done");
		d = 4'($random(seed));
		acc(1'b0, 8'hA5, d, 1'b1);
		rd(8'h05, d);
		$display("zero page done");
		results;
	end
endmodule
